// file: verilog/dfs_defs.vh
`ifndef DFS_DEFS_VH
`define DFS_DEFS_VH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DFS_REG_CTRL     8'h00
`define DFS_REG_INTERVAL 8'h04
`define DFS_REG_DATA     8'h08
`define DFS_REG_THRESH   8'h0C
`define DFS_REG_STATUS   8'h10
`define DFS_REG_CHAN0    8'h20
// ----------------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------------
`define DFS_CTRL_MODE_LO 0
`define DFS_CTRL_MODE_HI 1
`define DFS_CTRL_RUN     2
`define DFS_CTRL_TDIR_LO 3
`define DFS_CTRL_TDIR_HI 4
`define DFS_CTRL_SRST    5
`define DFS_CTRL_SWTRIG  6
`define DFS_CTRL_IRQEN   7
`define DFS_MODE_CONT    2'h0
`define DFS_MODE_RECYC   2'h1
`define DFS_MODE_SINGLE  2'h2
`define DFS_MODE_EXTTRIG 2'h3
`define DFS_TDIR_OFF     2'h0
`define DFS_TDIR_OUT     2'h1
`define DFS_TDIR_IN      2'h2
// ----------------------------------------------------------------------
// Queue entry and status fields
// ----------------------------------------------------------------------
`define DFS_ENT_TAG_LO   16
`define DFS_ENT_TAG_HI   18
`define DFS_ENT_EOS      19
`define DFS_ENT_W        20
`define DFS_ST_EMPTY     16
`define DFS_ST_FULL      17
`define DFS_ST_THR       18
`define DFS_ST_BUSY      19
// ----------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------
`define DFS_DEPTH        11'h400
`define DFS_AW           10
`define DFS_NCHAN        8
`define DFS_ZERO_CODE    16'h8000
`define DFS_CTRL_RST     8'h00
`define DFS_THRESH_RST   11'h000
// ----------------------------------------------------------------------
// Timing: interval limits and clock
// ----------------------------------------------------------------------
`define DFS_CLK_PS       8000
`define DFS_T_MIN_NS     12375
`define DFS_T_MAX_MS     2090
`define DFS_MIN_CYC      ((`DFS_T_MIN_NS * 1000 + `DFS_CLK_PS - 1) / `DFS_CLK_PS)
`define DFS_MAX_CYC      (`DFS_T_MAX_MS * (1000000000 / `DFS_CLK_PS))
`endif

// file: verilog/dfs_mem.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Sample queue storage, registered read port
// ----------------------------------------------------------------------
module dfs_mem
(
  input  wire        ref_clk,
  input  wire        we,
  input  wire [9:0]  waddr,
  input  wire [19:0] wdata,
  input  wire        re,
  input  wire [9:0]  raddr,
  output reg  [19:0] rdata
);
  reg [19:0] mem [0:1023];

  // No reset on the array; read data only matters after a read
  always @(posedge ref_clk)
  begin
    if (we)
      mem[waddr] <= wdata;
    if (re)
      rdata <= mem[raddr];
  end
endmodule // dfs_mem

// file: verilog/dfs_skid.v
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Two-entry buffer between bus writes and the queue
// ----------------------------------------------------------------------
module dfs_skid
(
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        flush,
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [19:0] in_data,
  output wire        out_valid,
  input  wire        out_ready,
  output wire [19:0] out_data
);
  reg  [19:0] ent0;
  reg  [19:0] ent1;
  reg  [1:0]  cnt;
  wire        push;
  wire        pop;

  assign in_ready  = (cnt != 2'h2);
  assign out_valid = (cnt != 2'h0);
  assign out_data  = ent0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Oldest word always sits in ent0
  always @(posedge ref_clk)
  begin
    if (rst | flush)
    begin
      cnt  <= 2'h0;
      ent0 <= 20'h00000;
      ent1 <= 20'h00000;
    end
    else
    begin
      if (pop)
        ent0 <= (cnt == 2'h2) ? ent1 : in_data;
      else if (push && cnt == 2'h0)
        ent0 <= in_data;
      if (push && (cnt == 2'h1) && !pop)
        ent1 <= in_data;
      cnt <= cnt + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // dfs_skid

// file: verilog/dfs_top.v
// Notes on behaviour
// - Queue holds 1024 entries, each tagged with its output channel.
// - Each pass reads entries into tagged channels until an end flag entry.
// - Channels without a new entry keep and re-output their code.
// - Interrupt request when waiting entries fall to programmed threshold.
// - Continuous mode drains entries once per timer period while selected.
// - Recycle replays entries from first written, wraps, discards nothing.
// - Interval timer spans 12.375 us to 2.09 s.
// - Fetch entries first, then one common update strobe for all channels.
// - Single mode pass started by software command or external trigger.
// - External trigger mode: each active edge starts one full conversion; here an edge that comes while a pass runs is dropped.
// - Trigger pin is output of our timing or input starting conversions.
// - Power-up, software and hardware reset load zero-volt code.
// - Channel registers and samples are 16 bits, bipolar.
//
// Added by the designer: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
`include "dfs_defs.vh"
module dfs_top
#(
  parameter [31:0] MIN_CYC = `DFS_MIN_CYC,
  parameter [31:0] MAX_CYC = `DFS_MAX_CYC
)
(
  input  wire         ref_clk,
  input  wire         rst,
  input  wire         hsel,
  input  wire [31:0]  haddr,
  input  wire [1:0]   htrans,
  input  wire         hwrite,
  input  wire [2:0]   hsize,
  input  wire [31:0]  hwdata,
  input  wire         hready,
  output wire         hreadyout,
  output wire         hresp,
  output reg  [31:0]  hrdata,
  output wire [127:0] dac_code,
  output reg          dac_update,
  input  wire         trig_in,
  output reg          trig_out,
  output reg          trig_oe_n,
  output wire         irq
);
  // --------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------
  localparam [1:0] S_IDLE = 2'h0;
  localparam [1:0] S_READ = 2'h1;
  localparam [1:0] S_LOAD = 2'h2;
  localparam [1:0] S_UPD  = 2'h3;

  // Register selected by a byte address
  function is_reg;
    input [31:0] addr;
    input [7:0]  off;
    begin
      is_reg = (addr[11:0] == {4'h0, off});
    end
  endfunction

  reg  [7:0]  ctrl;
  reg  [31:0] interval;
  reg  [10:0] thresh;
  reg         thr_flag;
  reg  [10:0] count;
  reg  [9:0]  wr_ptr;
  reg  [9:0]  rd_ptr;
  reg  [9:0]  rec_ptr;
  reg  [1:0]  state;
  reg  [1:0]  next_state;
  reg  [31:0] tmr;
  reg         trig_prev;
  reg         ap_valid;
  reg         ap_write;
  reg  [31:0] ap_addr;
  reg         srst;
  reg         swtrig;
  wire [1:0]  mode;
  wire [1:0]  tdir;
  wire        timed;
  wire        tick;
  wire        ext_edge;
  wire        start;
  wire        wr_phase;
  wire        data_wr;
  wire        skid_ready;
  wire        skid_valid;
  wire [19:0] skid_data;
  wire        q_full;
  wire        q_push;
  wire        q_pop;
  wire        mem_re;
  wire [9:0]  mem_raddr;
  wire [19:0] mem_rdata;
  wire [10:0] next_count;
  wire [31:0] eff_int;
  wire        thr_hit;
  wire        thr_clr;

  assign mode = ctrl[`DFS_CTRL_MODE_HI:`DFS_CTRL_MODE_LO];
  assign tdir = ctrl[`DFS_CTRL_TDIR_HI:`DFS_CTRL_TDIR_LO];

  // --------------------------------------------------------------------
  // AHB-Lite slave
  // --------------------------------------------------------------------
  assign wr_phase  = ap_valid & ap_write;
  assign data_wr   = wr_phase & is_reg(ap_addr, `DFS_REG_DATA);
  // Queue back-pressure stalls the data phase of a sample write
  assign hreadyout = ~(data_wr & ~skid_ready);
  assign hresp     = 1'b0;

  // Address phase capture
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ap_valid <= 1'b0;
      ap_write <= 1'b0;
      ap_addr  <= 32'h00000000;
    end
    else if (hready)
    begin
      ap_valid <= hsel & htrans[1];
      ap_write <= hwrite;
      ap_addr  <= haddr;
    end
  end

  // Read data registered during the address phase; unmapped reads zero
  always @(posedge ref_clk)
  begin
    if (rst)
      hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite)
    begin
      if (is_reg(haddr, `DFS_REG_CTRL))
        hrdata <= {24'h000000, ctrl};
      else if (is_reg(haddr, `DFS_REG_INTERVAL))
        hrdata <= interval;
      else if (is_reg(haddr, `DFS_REG_THRESH))
        hrdata <= {21'h000000, thresh};
      else if (is_reg(haddr, `DFS_REG_STATUS))
        hrdata <= {12'h000, (state != S_IDLE), thr_flag, q_full,
                   (count == 11'h000), 5'h00, count};
      else if (haddr[11:5] == 7'h01)
        hrdata <= {16'h0000, dac_code[{haddr[4:2], 4'h0} +: 16]};
      else
        hrdata <= 32'h00000000;
    end
  end

  // Control registers; soft reset and software trigger self-clear
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl     <= `DFS_CTRL_RST;
      interval <= MIN_CYC;
      thresh   <= `DFS_THRESH_RST;
      srst     <= 1'b0;
      swtrig   <= 1'b0;
    end
    else
    begin
      srst   <= 1'b0;
      swtrig <= 1'b0;
      if (wr_phase && is_reg(ap_addr, `DFS_REG_CTRL))
      begin
        ctrl <= {hwdata[7:6] & 2'h2, 1'b0, hwdata[4:0]};
        srst   <= hwdata[`DFS_CTRL_SRST];
        swtrig <= hwdata[`DFS_CTRL_SWTRIG];
      end
      if (wr_phase && is_reg(ap_addr, `DFS_REG_INTERVAL))
        interval <= hwdata;
      if (wr_phase && is_reg(ap_addr, `DFS_REG_THRESH))
        thresh <= hwdata[10:0];
    end
  end

  // --------------------------------------------------------------------
  // Write buffer and sample queue
  // --------------------------------------------------------------------
  dfs_skid u_skid
  (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .flush     (srst),
    .in_valid  (data_wr),
    .in_ready  (skid_ready),
    .in_data   (hwdata[19:0]),
    .out_valid (skid_valid),
    .out_ready (~q_full),
    .out_data  (skid_data)
  );

  assign q_full     = (count == `DFS_DEPTH);
  assign q_push     = skid_valid & ~q_full;
  assign mem_re     = (state == S_READ) && (count != 11'h000);
  // Recycle reads never consume; the other modes pop as they read
  assign q_pop      = mem_re && (mode != `DFS_MODE_RECYC);
  assign mem_raddr  = (mode == `DFS_MODE_RECYC) ? rec_ptr : rd_ptr;
  assign next_count = count + {10'h000, q_push} - {10'h000, q_pop};

  dfs_mem u_mem
  (
    .ref_clk (ref_clk),
    .we      (q_push),
    .waddr   (wr_ptr),
    .wdata   (skid_data),
    .re      (mem_re),
    .raddr   (mem_raddr),
    .rdata   (mem_rdata)
  );

  // Queue pointers; replay pointer wraps back to the oldest entry
  always @(posedge ref_clk)
  begin
    if (rst | srst)
    begin
      wr_ptr  <= 10'h000;
      rd_ptr  <= 10'h000;
      rec_ptr <= 10'h000;
      count   <= 11'h000;
    end
    else
    begin
      count <= next_count;
      if (q_push)
        wr_ptr <= wr_ptr + 10'h001;
      if (q_pop)
        rd_ptr <= rd_ptr + 10'h001;
      if (mode != `DFS_MODE_RECYC)
        rec_ptr <= rd_ptr;
      else if (mem_re)
        rec_ptr <= (rec_ptr + 10'h001 == wr_ptr) ? rd_ptr : rec_ptr + 10'h001;
    end
  end

  // --------------------------------------------------------------------
  // Threshold flag
  // --------------------------------------------------------------------
  assign thr_hit = q_pop && (next_count == thresh);
  assign thr_clr = wr_phase && is_reg(ap_addr, `DFS_REG_STATUS) && hwdata[`DFS_ST_THR];

  // Set wins over a clear in the same cycle
  always @(posedge ref_clk)
  begin
    if (rst | srst)
      thr_flag <= 1'b0;
    else if (thr_hit)
      thr_flag <= 1'b1;
    else if (thr_clr)
      thr_flag <= 1'b0;
  end

  assign irq = thr_flag & ctrl[`DFS_CTRL_IRQEN];

  // --------------------------------------------------------------------
  // Conversion interval timer
  // --------------------------------------------------------------------
  // Out-of-range intervals are clamped instead of refused
  assign eff_int = (interval < MIN_CYC) ? MIN_CYC :
                   (interval > MAX_CYC) ? MAX_CYC : interval;
  assign timed   = ctrl[`DFS_CTRL_RUN] &&
                   (mode == `DFS_MODE_CONT || mode == `DFS_MODE_RECYC);
  assign tick    = timed && (tmr == 32'h00000000);

  always @(posedge ref_clk)
  begin
    if (rst | srst)
      tmr <= MIN_CYC - 32'h00000001;
    else if (!timed || tick)
      tmr <= eff_int - 32'h00000001;
    else
      tmr <= tmr - 32'h00000001;
  end

  // --------------------------------------------------------------------
  // External trigger pin
  // --------------------------------------------------------------------
  assign ext_edge = (tdir == `DFS_TDIR_IN) && trig_in && !trig_prev;

  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      trig_prev <= 1'b0;
      trig_out  <= 1'b0;
      trig_oe_n <= 1'b1;
    end
    else
    begin
      trig_prev <= trig_in;
      trig_oe_n <= (tdir != `DFS_TDIR_OUT);
      trig_out  <= (tdir == `DFS_TDIR_OUT) && (next_state == S_UPD) &&
                   (state != S_UPD);
    end
  end

  // --------------------------------------------------------------------
  // Pass sequencer
  // --------------------------------------------------------------------
  // A start that arrives while a pass runs is dropped, not queued
  assign start = (timed && tick) ||
                 (mode == `DFS_MODE_SINGLE && (swtrig || ext_edge)) ||
                 (mode == `DFS_MODE_EXTTRIG && ext_edge);

  always @*
  begin
    next_state = state;
    case (state)
      S_IDLE:
        if (start)
          next_state = S_READ;
      S_READ:
        // An empty queue still ends with the common update
        next_state = (count != 11'h000) ? S_LOAD : S_UPD;
      S_LOAD:
        next_state = mem_rdata[`DFS_ENT_EOS] ? S_UPD : S_READ;
      S_UPD:
        next_state = S_IDLE;
      default:
        next_state = S_IDLE;
    endcase
  end

  always @(posedge ref_clk)
  begin
    if (rst | srst)
    begin
      state      <= S_IDLE;
      dac_update <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      dac_update <= (state == S_UPD);
    end
  end

  // --------------------------------------------------------------------
  // Channel code registers
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `DFS_NCHAN; gi = gi + 1)
    begin : g_chan
      localparam [2:0] CH_TAG = gi;
      reg [15:0] code;

      // Only the tagged channel loads; the rest hold their code
      always @(posedge ref_clk)
      begin
        if (rst | srst)
          code <= `DFS_ZERO_CODE;
        else if (state == S_LOAD &&
                 mem_rdata[`DFS_ENT_TAG_HI:`DFS_ENT_TAG_LO] == CH_TAG)
          code <= mem_rdata[15:0];
      end
      assign dac_code[gi*16 +: 16] = code;
    end
  endgenerate
endmodule // dfs_top

// file: verification/dfs_top_monitor.sv
`timescale 1ns/1ps
// --------------------------------------------
// Port checker for the output sequencer
// --------------------------------------------
module dfs_top_monitor
#(
  parameter [31:0] MIN_CYC = 32'd8,
  parameter [31:0] MAX_CYC = 32'd64
)
(
  input wire         ref_clk,
  input wire         rst,
  input wire         hsel,
  input wire [1:0]   htrans,
  input wire         hwrite,
  input wire         hreadyout,
  input wire [127:0] dac_code,
  input wire         dac_update,
  input wire         trig_out,
  input wire         trig_oe_n,
  input wire         irq
);
  // Write address phase seen on the bus
  wire wr_req = hsel && htrans[1] && hwrite;

  default clocking cb @(posedge ref_clk);
  endclocking

  // Reset must not be a disable here, it is the cause
  reset_zero_a: assert property (rst |=> dac_code == {8{16'h8000}})
    else $error("channel codes not at zero volt after reset");
  reset_idle_a: assert property (rst |=> trig_oe_n && !trig_out && !dac_update && !irq)
    else $error("outputs not idle after reset");
  update_once_a: assert property (disable iff (rst) dac_update |=> !dac_update)
    else $error("update strobe longer than one cycle");
  update_fetched_a: assert property (disable iff (rst) dac_update |-> $stable(dac_code))
    else $error("codes moved during the common strobe");
  trig_lead_a: assert property (disable iff (rst) trig_out |=> dac_update)
    else $error("trigger output not followed by update");
  trig_drive_a: assert property (disable iff (rst) trig_out |-> !trig_oe_n)
    else $error("trigger pulse while pin not driven");
  // Only a register write may drop a latched request
  irq_hold_a: assert property (disable iff (rst)
    $fell(irq) |-> ($past(wr_req, 1) || $past(wr_req, 2)))
    else $error("interrupt dropped without a write");
  stall_write_a: assert property (disable iff (rst)
    !hreadyout |-> ($past(wr_req) || $past(!hreadyout)))
    else $error("wait state outside a write data phase");

  cover property (dac_update);
  cover property (trig_out);
  cover property ($rose(irq));
endmodule // dfs_top_monitor

// file: verification/dfs_dac_model.sv
`timescale 1ns/1ps
// --------------------------------------------
// Converter channels and trigger source
// --------------------------------------------
module dfs_dac_model
(
  input  wire         ref_clk,
  input  wire [127:0] dac_code,
  input  wire         dac_update,
  input  wire         trig_req,
  output reg          trig_in,
  output reg  [127:0] cap
);
  reg [1:0] hold;

  initial
  begin
    trig_in = 1'b0;
    hold    = 2'h0;
    cap     = {8{16'h8000}};
  end

  // All eight converters take their codes on one strobe
  always @(posedge ref_clk)
    if (dac_update)
      cap <= dac_code;

  // Trigger held high a few cycles, so one edge per request
  always @(posedge ref_clk)
  begin
    hold    <= trig_req ? 2'h3 : (hold != 2'h0 ? hold - 2'h1 : 2'h0);
    trig_in <= trig_req || (hold != 2'h0);
  end
endmodule // dfs_dac_model

// file: verification/dfs_top_bench.sv
`timescale 1ns/1ps
`include "dfs_defs.vh"
module dfs_top_bench;
  reg          ref_clk, rst, hsel, hwrite, trig_req, rdy_n, upd_n;
  reg  [31:0]  haddr, hwdata, rd_n, q;
  reg  [1:0]   htrans;
  reg  [2:0]   hsize;
  reg  [15:0]  ex [0:7];
  wire         hreadyout, hresp, dac_update, trig_in, trig_out, trig_oe_n, irq;
  wire [31:0]  hrdata;
  wire [127:0] dac_code, cap;
  integer      n_fail, check_count, i, j, k;

  dfs_top #(.MIN_CYC(32'd8), .MAX_CYC(32'd64)) dfs_top_i (.ref_clk(ref_clk), .rst(rst),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .dac_code(dac_code), .dac_update(dac_update), .trig_in(trig_in),
    .trig_out(trig_out), .trig_oe_n(trig_oe_n), .irq(irq));
  dfs_dac_model dfs_dac_model_i (.ref_clk(ref_clk), .dac_code(dac_code),
    .dac_update(dac_update), .trig_req(trig_req), .trig_in(trig_in), .cap(cap));

  // --------------------------------------------
  // Clock, settled samples, watchdog
  // --------------------------------------------
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Outputs only move after rising edges, so mid-cycle is safe
  always @(negedge ref_clk)
  begin
    rdy_n = hreadyout;
    rd_n  = hrdata;
    upd_n = dac_update;
  end
  initial
  begin
    #(8 * 60000);
    n_fail = n_fail + 1;
    $display("unexpected at %0t: timeout", $time);
    conclude;
  end

  // --------------------------------------------
  // Bus and check tasks
  // --------------------------------------------
  task conclude;
    begin
      if (n_fail == 0 && check_count > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  // Address phase held until ready, then data phase held until ready
  task bus(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge ref_clk);
      hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
      @(posedge ref_clk);
      while (rdy_n !== 1'b1) @(posedge ref_clk);
      hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
      @(posedge ref_clk);
      while (rdy_n !== 1'b1) @(posedge ref_clk);
      q = rd_n;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    bus(1'b1, a, d);
  endtask
  task rd_chk(input [7:0] a, input [31:0] exp);
    begin
      bus(1'b0, a, 32'h0);
      chk(q, exp);
    end
  endtask
  // Every host entry carries its channel tag
  task put(input [2:0] ch, input [15:0] v, input e);
    begin
      wr(`DFS_REG_DATA, {12'h0, e, ch, v});
      ex[ch] = v;
    end
  endtask
  task chan_chk;
    for (j = 0; j < 8; j = j + 1)
      rd_chk(`DFS_REG_CHAN0 + {j[5:0], 2'b00}, {16'h0, ex[j]});
  endtask
  task chk_all;
    for (j = 0; j < 8; j = j + 1)
      chk({16'h0, cap[16*j +: 16]}, {16'h0, ex[j]});
  endtask
  // Counts edges to the next strobe, the spacing of passes
  task wait_upd;
    begin
      k = 0;
      @(posedge ref_clk);
      k = 1;
      while (upd_n !== 1'b1 && k < 3000)
      begin
        @(posedge ref_clk);
        k = k + 1;
      end
      // A strobe that never comes is a failure, not a silent pass
      if (upd_n !== 1'b1)
      begin
        n_fail = n_fail + 1;
        $display("unexpected at %0t: no update strobe", $time);
      end
      @(negedge ref_clk);
    end
  endtask
  task pulse;
    begin
      @(posedge ref_clk) trig_req <= 1'b1;
      @(posedge ref_clk) trig_req <= 1'b0;
    end
  endtask
  function [31:0] cw(input [1:0] m, input r, input [1:0] t, input ie, input sw, input sr);
    cw = {24'h0, ie, sw, sr, t, r, m};
  endfunction

  // --------------------------------------------
  // Test sequence
  // --------------------------------------------
  initial
  begin
    rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; trig_req = 1'b0; n_fail = 0; check_count = 0;
    for (i = 0; i < 8; i = i + 1) ex[i] = `DFS_ZERO_CODE;
    repeat (20) @(posedge ref_clk);
    rst <= 1'b0;
    chan_chk;
    rd_chk(`DFS_REG_STATUS, 32'h0001_0000);
    rd_chk(`DFS_REG_INTERVAL, 32'd8);
    rd_chk(8'h40, 32'h0);
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_SINGLE, 1'b0, `DFS_TDIR_OFF, 1'b0, 1'b0, 1'b0));
    put(3'h3, 16'hFFFF, 1'b1);
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_SINGLE, 1'b0, `DFS_TDIR_OFF, 1'b0, 1'b1, 1'b0));
    wait_upd;
    chk_all;
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_SINGLE, 1'b0, `DFS_TDIR_IN, 1'b0, 1'b0, 1'b0));
    put(3'h6, 16'h0001, 1'b1);
    pulse;
    wait_upd;
    chk_all;
    chk({31'h0, trig_oe_n}, 32'h1);
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_EXTTRIG, 1'b0, `DFS_TDIR_IN, 1'b0, 1'b0, 1'b0));
    put(3'h0, 16'h1111, 1'b0);
    put(3'h7, 16'h7777, 1'b1);
    pulse;
    wait_upd;
    chk_all;
    // Entries queued before the run starts, so the pass never starves
    wr(`DFS_REG_INTERVAL, 32'd2);
    rd_chk(`DFS_REG_INTERVAL, 32'd2);
    put(3'h1, 16'h4321, 1'b0);
    put(3'h2, 16'h0002, 1'b1);
    // Spare entry feeds the second pass; spacing is then timed in recycle
    wr(`DFS_REG_DATA, {12'h0, 1'b1, 3'h1, 16'h4321});
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_CONT, 1'b1, `DFS_TDIR_OUT, 1'b0, 1'b0, 1'b0));
    wait_upd;
    chk_all;
    chk({31'h0, trig_oe_n}, 32'h0);
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_RECYC, 1'b1, `DFS_TDIR_OUT, 1'b0, 1'b0, 1'b0));
    // First strobes may still carry the old pass length or interval
    repeat (3) wait_upd;
    chk(k, 32'd8);
    wr(`DFS_REG_INTERVAL, 32'd100);
    repeat (3) wait_upd;
    chk(k, 32'd64);
    wr(`DFS_REG_CTRL, 32'h0);
    wr(`DFS_REG_THRESH, 32'd1);
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_SINGLE, 1'b0, `DFS_TDIR_OFF, 1'b1, 1'b0, 1'b0));
    put(3'h5, 16'h5555, 1'b1);
    put(3'h4, 16'h5AAA, 1'b1);
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_SINGLE, 1'b0, `DFS_TDIR_OFF, 1'b1, 1'b1, 1'b0));
    wait_upd;
    chk({31'h0, irq}, 32'h1);
    rd_chk(`DFS_REG_STATUS, 32'h0004_0001);
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_SINGLE, 1'b0, `DFS_TDIR_OFF, 1'b0, 1'b0, 1'b0));
    repeat (2) @(negedge ref_clk);
    chk({31'h0, irq}, 32'h0);
    wr(`DFS_REG_STATUS, 32'h0004_0000);
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_SINGLE, 1'b0, `DFS_TDIR_OFF, 1'b1, 1'b1, 1'b0));
    wait_upd;
    chk({31'h0, irq}, 32'h0);
    chk_all;
    wr(`DFS_REG_CTRL, 32'h0);
    for (i = 0; i < 1024; i = i + 1)
      wr(`DFS_REG_DATA, {12'h0, 1'b0, i[2:0], i[15:0]});
    rd_chk(`DFS_REG_STATUS, 32'h0002_0400);
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_CONT, 1'b0, `DFS_TDIR_OFF, 1'b0, 1'b0, 1'b1));
    for (i = 0; i < 8; i = i + 1) ex[i] = `DFS_ZERO_CODE;
    rd_chk(`DFS_REG_STATUS, 32'h0001_0000);
    chan_chk;
    put(3'h2, 16'h2A2A, 1'b1);
    wr(`DFS_REG_DATA, {12'h0, 1'b1, 3'h2, 16'h2B2B});
    wr(`DFS_REG_CTRL, cw(`DFS_MODE_RECYC, 1'b1, `DFS_TDIR_OFF, 1'b0, 1'b0, 1'b0));
    for (i = 0; i < 3; i = i + 1)
    begin
      wait_upd;
      chk({16'h0, cap[47:32]}, (i == 1) ? 32'h2B2B : 32'h2A2A);
    end
    wr(`DFS_REG_CTRL, 32'h0);
    conclude;
  end
endmodule // dfs_top_bench

bind dfs_top dfs_top_monitor #(.MIN_CYC(MIN_CYC), .MAX_CYC(MAX_CYC)) dfs_top_monitor_i
  (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hreadyout(hreadyout), .dac_code(dac_code), .dac_update(dac_update),
   .trig_out(trig_out), .trig_oe_n(trig_oe_n), .irq(irq));
